// ===== src/pm_local_regs.sv
// Local power-management status register bank with AXI4-Lite slave
//
// Contract
// - Warm-from-D2 flag is read-only
// - Flag set: wakeup assertion in D2 warms
// - Warm only with host reset off, clock on
// - Flag reset by device reset only
// - Enable field reads host enable bit
// - Writing 1 to enable clears both bits
// - Enable reset by device and warm reset
// - Wakeup level bit follows pin, no reset
// - Status field reads host sticky status
// - Writing 1 to status sets status
// - Both written 1: clear both bits
// - Driven flag read-only, shows PME driven
// - Driven flag high while enable and status
// - Aux detect bit follows pin, resettable
// - Current power state field, D2 is 2
//
// The implementer's own choices: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
module pm_local_regs #(
    parameter int SYNC_STAGES = 2
) (
    // Clock and resets
    input  wire logic        I_CORE_CLK,
    input  wire logic        I_RESET,
    input  wire logic        I_WARM_RESET,
    // AXI4-Lite write address and data
    input  wire logic [7:0]  I_AWADDR,
    input  wire logic        I_AWVALID,
    output logic             O_AWREADY,
    input  wire logic [31:0] I_WDATA,
    input  wire logic [3:0]  I_WSTRB,
    input  wire logic        I_WVALID,
    output logic             O_WREADY,
    // AXI4-Lite write response
    output logic [1:0]       O_BRESP,
    output logic             O_BVALID,
    input  wire logic        I_BREADY,
    // AXI4-Lite read
    input  wire logic [7:0]  I_ARADDR,
    input  wire logic        I_ARVALID,
    output logic             O_ARREADY,
    output logic [31:0]      O_RDATA,
    output logic [1:0]       O_RRESP,
    output logic             O_RVALID,
    input  wire logic        I_RREADY,
    // Pins and straps
    input  wire logic        I_WAKEUP_REQUEST_PIN,
    input  wire logic        I_AUX_SUPPLY_DETECT,
    input  wire logic        I_D2_WARM_STRAP,
    input  wire logic        I_HOST_BUS_RESET,
    input  wire logic        I_HOST_CLK_ACTIVE,
    // Host side of the enable and status bits
    input  wire logic        I_HOST_PME_EN_WE,
    input  wire logic        I_HOST_PME_EN_WDATA,
    input  wire logic        I_HOST_PME_STAT_CLR,
    input  wire logic        I_PME_EVENT,
    output logic             O_HOST_PME_EN,
    output logic             O_HOST_PME_STAT,
    output logic             O_PME_ACTIVE,
    // Warm reset request and interrupt
    output logic             O_WARM_RESET_REQ,
    output logic             O_IRQ
);
    // ========================================================
    // Declarations
    logic        aw_held_r;
    logic [7:0]  awaddr_r;
    logic        w_held_r;
    logic [31:0] wdata_r;
    logic [3:0]  wstrb_r;
    logic        bvalid_r;
    logic [1:0]  bresp_r;
    logic        rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0]  rresp_r;
    logic        wr_fire;
    logic        ar_fire;
    logic        csr_wr;
    logic        en_clr;
    logic        stat_set;
    logic        flag_r;
    logic        pme_en_r;
    logic        pme_stat_r;
    logic        drvn_r;
    logic        aux_r;
    logic [1:0]  cur_state_r;
    logic [1:0]  ist_r;
    logic [1:0]  ist_nxt;
    logic [1:0]  mask_r;
    logic        irq_r;
    logic        pme_now;
    logic        ist_rd;
    logic        warm_req;
    logic        wkp_sync;
    logic        aux_sync;
    logic [31:0] csr_val;

    // Address decode shared by read and write paths
    function automatic logic [1:0] reg_sel(input logic [7:0] a);
        case (a)
            pm_local_pkg::OFF_PM_CSR:   reg_sel = pm_local_pkg::SEL_PM_CSR;
            pm_local_pkg::OFF_IRQ_STAT: reg_sel = pm_local_pkg::SEL_IRQ_STAT;
            pm_local_pkg::OFF_IRQ_MASK: reg_sel = pm_local_pkg::SEL_IRQ_MASK;
            default:                    reg_sel = pm_local_pkg::SEL_NONE;
        endcase
    endfunction

    // ========================================================
    // Pin synchronisers and warm-reset generator
    pm_pin_sync #(
        .W      (2),
        .STAGES (SYNC_STAGES)
    ) u_sync (
        .i_clk   (I_CORE_CLK),
        .i_async ({I_AUX_SUPPLY_DETECT, I_WAKEUP_REQUEST_PIN}),
        .o_sync  ({aux_sync, wkp_sync})
    );

    pm_warm_gen u_warm (
        .i_clk             (I_CORE_CLK),
        .i_reset           (I_RESET),
        .i_wkp_level       (wkp_sync),
        .i_flag            (flag_r),
        .i_cur_state       (cur_state_r),
        .i_host_bus_reset  (I_HOST_BUS_RESET),
        .i_host_clk_active (I_HOST_CLK_ACTIVE),
        .o_warm_req        (warm_req)
    );

    // ========================================================
    // AXI write channels: address and data taken in any order
    assign O_AWREADY = !aw_held_r;
    assign O_WREADY  = !w_held_r;
    assign wr_fire   = aw_held_r && w_held_r && !bvalid_r;

    always_ff @(posedge I_CORE_CLK) begin
        if (I_RESET) begin
            aw_held_r <= 1'b0;
            awaddr_r  <= 8'h00;
        end else if (I_AWVALID && !aw_held_r) begin
            aw_held_r <= 1'b1;
            awaddr_r  <= I_AWADDR;
        end else if (wr_fire) begin
            aw_held_r <= 1'b0;
        end
    end

    always_ff @(posedge I_CORE_CLK) begin
        if (I_RESET) begin
            w_held_r <= 1'b0;
            wdata_r  <= 32'h0000_0000;
            wstrb_r  <= 4'h0;
        end else if (I_WVALID && !w_held_r) begin
            w_held_r <= 1'b1;
            wdata_r  <= I_WDATA;
            wstrb_r  <= I_WSTRB;
        end else if (wr_fire) begin
            w_held_r <= 1'b0;
        end
    end

    // Response stands until the master takes it
    always_ff @(posedge I_CORE_CLK) begin
        if (I_RESET) begin
            bvalid_r <= 1'b0;
            bresp_r  <= pm_local_pkg::RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_r <= 1'b1;
            bresp_r  <= (reg_sel(awaddr_r) == pm_local_pkg::SEL_NONE) ?
                        pm_local_pkg::RESP_SLVERR : pm_local_pkg::RESP_OKAY;
        end else if (I_BREADY) begin
            bvalid_r <= 1'b0;
        end
    end

    assign O_BVALID = bvalid_r;
    assign O_BRESP  = bresp_r;

    // ========================================================
    // Local write decode for the control/status register
    assign csr_wr   = wr_fire &&
                      (reg_sel(awaddr_r) == pm_local_pkg::SEL_PM_CSR);
    assign en_clr   = csr_wr && wstrb_r[1] &&
                      wdata_r[pm_local_pkg::BIT_PME_EN];
    assign stat_set = csr_wr && wstrb_r[0] &&
                      wdata_r[pm_local_pkg::BIT_PME_STAT];

    // Strap captured only by device reset; writes never reach it
    always_ff @(posedge I_CORE_CLK) begin
        if (I_RESET) begin
            flag_r <= I_D2_WARM_STRAP;
        end
    end

    // Current power state, untouched by warm or host reset
    always_ff @(posedge I_CORE_CLK) begin
        if (I_RESET) begin
            cur_state_r <= pm_local_pkg::CUR_RST;
        end else if (csr_wr && wstrb_r[0]) begin
            cur_state_r <= wdata_r[pm_local_pkg::CUR_LSB +:
                                   pm_local_pkg::CUR_W];
        end
    end

    // Host enable bit: local clear beats a host write
    always_ff @(posedge I_CORE_CLK) begin
        if (I_RESET || I_WARM_RESET) begin
            pme_en_r <= 1'b0;
        end else if (en_clr) begin
            pme_en_r <= 1'b0;
        end else if (I_HOST_PME_EN_WE) begin
            pme_en_r <= I_HOST_PME_EN_WDATA;
        end
    end

    // Sticky status; a hardware event is never lost to a clear
    always_ff @(posedge I_CORE_CLK) begin
        if (I_RESET || I_WARM_RESET) begin
            pme_stat_r <= 1'b0;
        end else if (I_PME_EVENT || (stat_set && !en_clr)) begin
            pme_stat_r <= 1'b1;
        end else if (en_clr || I_HOST_PME_STAT_CLR) begin
            pme_stat_r <= 1'b0;
        end
    end

    // Driven flag follows enable and status; a read leaves it
    assign pme_now = pme_en_r && pme_stat_r;
    always_ff @(posedge I_CORE_CLK) begin
        if (I_RESET || I_WARM_RESET) begin
            drvn_r <= 1'b0;
        end else begin
            drvn_r <= pme_now;
        end
    end

    // Aux detect sample, cleared by both resets
    always_ff @(posedge I_CORE_CLK) begin
        if (I_RESET || I_WARM_RESET) begin
            aux_r <= 1'b0;
        end else begin
            aux_r <= aux_sync;
        end
    end

    assign O_HOST_PME_EN    = pme_en_r;
    assign O_HOST_PME_STAT  = pme_stat_r;
    assign O_PME_ACTIVE     = drvn_r;
    assign O_WARM_RESET_REQ = warm_req;

    // ========================================================
    // Interrupts: read of the status clears it, set wins
    assign ist_rd  = ar_fire &&
                     (reg_sel(I_ARADDR) == pm_local_pkg::SEL_IRQ_STAT);
    assign ist_nxt = (ist_rd ? 2'h0 : ist_r) |
                     {pme_now && !drvn_r, warm_req};

    always_ff @(posedge I_CORE_CLK) begin
        if (I_RESET) begin
            ist_r <= 2'h0;
        end else begin
            ist_r <= ist_nxt;
        end
    end

    always_ff @(posedge I_CORE_CLK) begin
        if (I_RESET) begin
            mask_r <= pm_local_pkg::IRQ_MASK_RST;
        end else if (wr_fire && wstrb_r[0] &&
                     reg_sel(awaddr_r) == pm_local_pkg::SEL_IRQ_MASK) begin
            mask_r <= wdata_r[pm_local_pkg::IRQ_W-1:0];
        end
    end

    always_ff @(posedge I_CORE_CLK) begin
        if (I_RESET) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= |(ist_nxt & mask_r);
        end
    end

    assign O_IRQ = irq_r;

    // ========================================================
    // Read path; upper reserved and out-of-scope bits read zero
    always_comb begin
        csr_val = 32'h0000_0000;
        csr_val[pm_local_pkg::BIT_D2_FLAG]  = flag_r;
        csr_val[pm_local_pkg::BIT_PME_EN]   = pme_en_r;
        csr_val[pm_local_pkg::BIT_WKP_LVL]  = wkp_sync;
        csr_val[pm_local_pkg::BIT_PME_STAT] = pme_stat_r;
        csr_val[pm_local_pkg::BIT_PME_DRVN] = drvn_r;
        csr_val[pm_local_pkg::BIT_AUX_DET]  = aux_r;
        csr_val[pm_local_pkg::CUR_LSB +: pm_local_pkg::CUR_W] = cur_state_r;
    end

    assign O_ARREADY = !rvalid_r;
    assign ar_fire   = I_ARVALID && !rvalid_r;

    always_ff @(posedge I_CORE_CLK) begin
        if (I_RESET) begin
            rvalid_r <= 1'b0;
            rdata_r  <= 32'h0000_0000;
            rresp_r  <= pm_local_pkg::RESP_OKAY;
        end else if (ar_fire) begin
            rvalid_r <= 1'b1;
            rresp_r  <= pm_local_pkg::RESP_OKAY;
            case (reg_sel(I_ARADDR))
                pm_local_pkg::SEL_PM_CSR:   rdata_r <= csr_val;
                pm_local_pkg::SEL_IRQ_STAT: rdata_r <= {30'h0, ist_r};
                pm_local_pkg::SEL_IRQ_MASK: rdata_r <= {30'h0, mask_r};
                default: begin
                    rdata_r <= 32'h0000_0000;
                    rresp_r <= pm_local_pkg::RESP_SLVERR;
                end
            endcase
        end else if (I_RREADY) begin
            rvalid_r <= 1'b0;
        end
    end

    assign O_RVALID = rvalid_r;
    assign O_RDATA  = rdata_r;
    assign O_RRESP  = rresp_r;

    // ========================================================
    // Checks
    default clocking cb @(posedge I_CORE_CLK); endclocking
    default disable iff (I_RESET);

    sequence both_written_s;
        en_clr && stat_set;
    endsequence

    sequence csr_read_s;
        ar_fire && reg_sel(I_ARADDR) == pm_local_pkg::SEL_PM_CSR;
    endsequence

    flag_stable_a: assert property (##1 $stable(flag_r))
        else $error("warm flag changed outside device reset");
    en_clear_a: assert property (en_clr && !I_PME_EVENT |=>
        !pme_en_r && !pme_stat_r)
        else $error("enable write did not clear both bits");
    stat_set_a: assert property (stat_set && !en_clr |=> pme_stat_r)
        else $error("status write did not set status");
    both_clear_a: assert property (both_written_s ##0 !I_PME_EVENT
        |=> !pme_stat_r)
        else $error("double write set status");
    warm_clear_a: assert property (I_WARM_RESET |=>
        !pme_en_r && !pme_stat_r && !drvn_r && !aux_r)
        else $error("warm reset left a field set");
    drvn_track_a: assert property (!I_WARM_RESET |=>
        drvn_r == $past(pme_now))
        else $error("driven flag not following enable and status");
    csr_read_a: assert property (csr_read_s |=> rvalid_r &&
        rdata_r[pm_local_pkg::BIT_PME_EN] == $past(pme_en_r) &&
        rdata_r[pm_local_pkg::BIT_PME_STAT] == $past(pme_stat_r) &&
        rdata_r[pm_local_pkg::BIT_WKP_LVL] == $past(wkp_sync))
        else $error("register read value wrong");
    aux_follow_a: assert property (!I_WARM_RESET |=>
        aux_r == $past(aux_sync))
        else $error("aux detect bit not following pin");
    bresp_hold_a: assert property (bvalid_r && !I_BREADY |=> bvalid_r)
        else $error("write response dropped early");
endmodule

// ===== pkg/pm_local_pkg.sv
// Constants for the local power-management status register block
package pm_local_pkg;
    // ========================================================
    // Bus geometry and register offsets
    localparam int          ADDR_W       = 8;
    localparam int          DATA_W       = 32;
    localparam logic [7:0]  OFF_PM_CSR   = 8'h00;
    localparam logic [7:0]  OFF_IRQ_STAT = 8'h04;
    localparam logic [7:0]  OFF_IRQ_MASK = 8'h08;
    // Register select codes
    localparam logic [1:0]  SEL_PM_CSR   = 2'h0;
    localparam logic [1:0]  SEL_IRQ_STAT = 2'h1;
    localparam logic [1:0]  SEL_IRQ_MASK = 2'h2;
    localparam logic [1:0]  SEL_NONE     = 2'h3;
    // AXI responses
    localparam logic [1:0]  RESP_OKAY    = 2'h0;
    localparam logic [1:0]  RESP_SLVERR  = 2'h2;
    // ========================================================
    // Field positions of power_mgmt_local_control_status
    localparam int          BIT_D2_FLAG  = 9;
    localparam int          BIT_PME_EN   = 8;
    localparam int          BIT_WKP_LVL  = 7;
    localparam int          BIT_PME_STAT = 6;
    localparam int          BIT_PME_DRVN = 5;
    localparam int          BIT_AUX_DET  = 4;
    localparam int          CUR_LSB      = 2;
    localparam int          CUR_W        = 2;
    // Power state codes and reset values
    localparam logic [1:0]  PWR_D2       = 2'h2;
    localparam logic [1:0]  CUR_RST      = 2'h0;
    // ========================================================
    // Interrupt status and mask layout
    localparam int          IRQ_W        = 2;
    localparam int          IRQ_WARM     = 0;
    localparam int          IRQ_PME      = 1;
    localparam logic [1:0]  IRQ_MASK_RST = 2'h0;
    // Minimum synchroniser depth
    localparam int          SYNC_MIN     = 2;
endpackage

// ===== src/pm_pin_sync.sv
// Multi-stage synchroniser for asynchronous pin levels
`timescale 1ns/1ps
module pm_pin_sync #(
    parameter int W      = 2,
    parameter int STAGES = 2
) (
    // Clock
    input  wire logic         i_clk,
    // Pin levels in, synchronised levels out
    input  wire logic [W-1:0] i_async,
    output logic      [W-1:0] o_sync
);
    logic [W-1:0] stage_r [STAGES];

    // ========================================================
    // Elaboration check
    if (STAGES < pm_local_pkg::SYNC_MIN) begin : g_bad
        $error("pm_pin_sync needs at least two stages");
    end

    // No reset: the pin level has no reset source of its own
    always_ff @(posedge i_clk) begin
        stage_r[0] <= i_async;
        for (int k = 1; k < STAGES; k++) begin
            stage_r[k] <= stage_r[k-1];
        end
    end

    assign o_sync = stage_r[STAGES-1];
endmodule

// ===== src/pm_warm_gen.sv
// Warm-reset request generator from the wakeup request pin
`timescale 1ns/1ps
module pm_warm_gen (
    // Clock and reset
    input  wire logic       i_clk,
    input  wire logic       i_reset,
    // Conditions
    input  wire logic       i_wkp_level,
    input  wire logic       i_flag,
    input  wire logic [1:0] i_cur_state,
    input  wire logic       i_host_bus_reset,
    input  wire logic       i_host_clk_active,
    // One-cycle request
    output logic            o_warm_req
);
    logic prev_r;
    logic assert_edge;
    logic allowed;

    // Pin is active low; falling edge is the assertion
    assign assert_edge = prev_r && !i_wkp_level;
    assign allowed     = !i_host_bus_reset && i_host_clk_active;

    // ========================================================
    // Previous pin level, idle high after reset
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            prev_r <= 1'b1;
        end else begin
            prev_r <= i_wkp_level;
        end
    end

    // Request only in D2, flag set, host bus alive
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_warm_req <= 1'b0;
        end else begin
            o_warm_req <= assert_edge && i_flag &&
                          (i_cur_state == pm_local_pkg::PWR_D2) &&
                          allowed;
        end
    end

    // ========================================================
    // Checks
    warm_cause_a: assert property (@(posedge i_clk) disable iff (i_reset)
        o_warm_req |-> $past(i_flag) &&
            $past(i_cur_state) == pm_local_pkg::PWR_D2 &&
            $past(prev_r) && !$past(i_wkp_level))
        else $error("warm request without its cause");
    warm_host_a: assert property (@(posedge i_clk) disable iff (i_reset)
        (i_host_bus_reset || !i_host_clk_active) |=> !o_warm_req)
        else $error("warm request while host bus down");
endmodule

// ===== verif/pm_host_model.sv
// Behavioural host power-management side and board pin drivers
`timescale 1ns/1ps
module pm_host_model (
    // Clock
    input  wire logic i_clk,
    // Host register pulses
    output logic      o_en_we,
    output logic      o_en_wdata,
    output logic      o_stat_clr,
    output logic      o_pme_event,
    // Board pins and host bus state
    output logic      o_wakeup_pin,
    output logic      o_aux_detect,
    output logic      o_host_bus_reset,
    output logic      o_host_clk_active
);
    // ========================================================
    // Idle host: bus out of reset, clock running, wakeup pin idle high
    initial begin
        o_en_we = 1'b0;
        o_en_wdata = 1'b0;
        o_stat_clr = 1'b0;
        o_pme_event = 1'b0;
        o_wakeup_pin = 1'b1;
        o_aux_detect = 1'b0;
        o_host_bus_reset = 1'b0;
        o_host_clk_active = 1'b1;
    end

    // Single-cycle host writes, entered just after a rising edge
    task automatic en_write(input logic v);
        o_en_we <= 1'b1;
        o_en_wdata <= v;
        @(posedge i_clk);
        o_en_we <= 1'b0;
    endtask

    task automatic wake_event();
        o_pme_event <= 1'b1;
        @(posedge i_clk);
        o_pme_event <= 1'b0;
    endtask

    task automatic stat_clear();
        o_stat_clr <= 1'b1;
        @(posedge i_clk);
        o_stat_clr <= 1'b0;
    endtask

    // Pins are plain levels, held until changed again
    task automatic set_pins(input logic w, input logic a);
        o_wakeup_pin <= w;
        o_aux_detect <= a;
    endtask

    task automatic set_bus(input logic r, input logic c);
        o_host_bus_reset <= r;
        o_host_clk_active <= c;
    endtask
endmodule

// ===== verif/pm_local_regs_test.sv
// Self-checking bench for the local power-management register bank
`timescale 1ns/1ps
module pm_local_regs_test;
    // ========================================================
    // Bench signals
    logic        clk = 0, rst = 1, warm = 0, strap = 1, seen;
    logic [7:0]  awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rdata, bus_rdata;
    logic [3:0]  wstrb = 0;
    logic        awvalid = 0, wvalid = 0, bready = 0;
    logic        arvalid = 0, rready = 0;
    logic        awready, wready, bvalid, arready, rvalid;
    logic        en_we, en_wd, st_clr, pme_ev, wkp, aux, hrst, hclk;
    logic        h_en, h_st, pme_act, wreq, irq;
    logic [1:0]  bresp, rresp, resp, st;
    logic [15:0] lfsr = 16'he1e5;
    int          failures = 0, n_checks = 0;

    always #4 clk = ~clk;

    pm_local_regs #(.SYNC_STAGES(2)) DUT (
        .I_CORE_CLK(clk), .I_RESET(rst), .I_WARM_RESET(warm),
        .I_AWADDR(awaddr), .I_AWVALID(awvalid), .O_AWREADY(awready),
        .I_WDATA(wdata), .I_WSTRB(wstrb), .I_WVALID(wvalid),
        .O_WREADY(wready), .O_BRESP(bresp), .O_BVALID(bvalid),
        .I_BREADY(bready), .I_ARADDR(araddr), .I_ARVALID(arvalid),
        .O_ARREADY(arready), .O_RDATA(bus_rdata), .O_RRESP(rresp),
        .O_RVALID(rvalid), .I_RREADY(rready),
        .I_WAKEUP_REQUEST_PIN(wkp), .I_AUX_SUPPLY_DETECT(aux),
        .I_D2_WARM_STRAP(strap), .I_HOST_BUS_RESET(hrst),
        .I_HOST_CLK_ACTIVE(hclk), .I_HOST_PME_EN_WE(en_we),
        .I_HOST_PME_EN_WDATA(en_wd), .I_HOST_PME_STAT_CLR(st_clr),
        .I_PME_EVENT(pme_ev), .O_HOST_PME_EN(h_en), .O_HOST_PME_STAT(h_st),
        .O_PME_ACTIVE(pme_act), .O_WARM_RESET_REQ(wreq), .O_IRQ(irq));

    pm_host_model host (
        .i_clk(clk), .o_en_we(en_we), .o_en_wdata(en_wd),
        .o_stat_clr(st_clr), .o_pme_event(pme_ev), .o_wakeup_pin(wkp),
        .o_aux_detect(aux), .o_host_bus_reset(hrst),
        .o_host_clk_active(hclk));

    // ========================================================
    // Expectation helpers
    function automatic logic [15:0] next_lfsr(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction

    function automatic logic [31:0] exp_csr(input logic f, e, l, s, d, a,
                                            input logic [1:0] c);
        return {22'h0, f, e, l, s, d, a, c, 2'b00};
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    // ========================================================
    // AXI4-Lite master; bounded waits, no assumed latency
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      output logic [1:0] r);
        int n;
        n = 0;
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'hf;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk);
            n++;
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1 && n < 64);
        r = bresp;
        bready <= 1'b0;
        if (n >= 64) begin
            failures++;
            results();
        end
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        int n;
        n = 0;
        // One edge first, so a back-to-back read never re-drives rready
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk);
            n++;
            if (arvalid && arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1 && n < 64);
        d = bus_rdata;
        resp = rresp;
        rready <= 1'b0;
        if (n >= 64) begin
            failures++;
            results();
        end
    endtask

    // Looks for the one-cycle warm request over a fixed window
    task automatic watch(output logic s);
        s = 1'b0;
        repeat (8) begin
            @(posedge clk);
            if (wreq === 1'b1) s = 1'b1;
        end
    endtask

    task automatic results;
        $display("checks=%0d failures=%0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // Hang guard, well beyond the few hundred cycles the tests need
    initial begin
        wait_cyc(20000);
        failures++;
        results();
    end

    // ========================================================
    // Main sequence
    initial begin
        wait_cyc(8);
        rst <= 1'b0;
        @(posedge clk);
        rd(8'h00, rdata); chk(rdata, exp_csr(1, 0, 1, 0, 0, 0, 0));
        wr(8'h00, 32'h2b0, resp); rd(8'h00, rdata);
        chk(rdata, exp_csr(1, 0, 1, 0, 0, 0, 0));
        $display("reset and read-only test done");
        // Host sets enable and status; interrupt and driven flag follow
        wr(8'h08, 32'h2, resp);
        chk({30'h0, resp}, 32'h0);
        host.en_write(1'b1);
        host.wake_event();
        wait_cyc(3);
        chk({31'h0, irq}, 32'h1);
        rd(8'h00, rdata); chk(rdata, exp_csr(1, 1, 1, 1, 1, 0, 0));
        rd(8'h00, rdata); chk(rdata, exp_csr(1, 1, 1, 1, 1, 0, 0));
        rd(8'h04, rdata); chk(rdata, 32'h2);
        wait_cyc(2);
        chk({31'h0, irq}, 32'h0);
        host.stat_clear();
        wait_cyc(2);
        rd(8'h00, rdata); chk(rdata, exp_csr(1, 1, 1, 0, 0, 0, 0));
        wr(8'h00, 32'h100, resp); rd(8'h00, rdata);
        chk(rdata, exp_csr(1, 0, 1, 0, 0, 0, 0));
        wr(8'h00, 32'h40, resp); rd(8'h00, rdata);
        chk(rdata, exp_csr(1, 0, 1, 1, 0, 0, 0));
        host.en_write(1'b1);
        wr(8'h00, 32'h140, resp); rd(8'h00, rdata);
        chk(rdata, exp_csr(1, 0, 1, 0, 0, 0, 0));
        host.en_write(1'b1);
        wr(8'h00, 32'h0, resp); rd(8'h00, rdata);
        chk(rdata, exp_csr(1, 1, 1, 0, 0, 0, 0));
        $display("enable and status test done");
        // Random pin levels must show up after synchronisation
        for (int i = 0; i < 8; i++) begin
            lfsr = next_lfsr(lfsr);
            host.set_pins(lfsr[0], lfsr[1]);
            wait_cyc(4);
            rd(8'h00, rdata);
            chk(rdata & 32'h90, {24'h0, lfsr[0], 2'b00, lfsr[1], 4'h0});
        end
        host.set_pins(1'b1, 1'b0);
        $display("pin level test done");
        // Warm request only with host bus up, clock on and state D2
        for (int k = 0; k < 4; k++) begin
            st = (k == 3) ? 2'h1 : pm_local_pkg::PWR_D2;
            wr(8'h00, {28'h0, st, 2'b00}, resp);
            host.set_bus(k == 1, k != 2);
            wait_cyc(4);
            host.set_pins(1'b0, 1'b0);
            watch(seen);
            chk({31'h0, seen}, {31'h0, k == 0});
            host.set_pins(1'b1, 1'b0);
            wait_cyc(4);
        end
        rd(8'h04, rdata); chk(rdata, 32'h3);
        // Warm reset clears host bits but keeps flag and state
        host.set_bus(1'b0, 1'b1);
        host.wake_event();
        wait_cyc(2);
        chk({29'h0, h_en, h_st, pme_act}, 32'h7);
        warm <= 1'b1;
        @(posedge clk);
        warm <= 1'b0;
        wait_cyc(2);
        rd(8'h00, rdata); chk(rdata, exp_csr(1, 0, 1, 0, 0, 0, 1));
        chk({29'h0, h_en, h_st, pme_act}, 32'h0);
        // Flag cleared by a second device reset blocks the request
        strap <= 1'b0;
        rst <= 1'b1;
        wait_cyc(2);
        rst <= 1'b0;
        @(posedge clk);
        rd(8'h00, rdata); chk(rdata, exp_csr(0, 0, 1, 0, 0, 0, 0));
        wr(8'h00, 32'h8, resp);
        host.set_pins(1'b0, 1'b0);
        watch(seen);
        chk({31'h0, seen}, 32'h0);
        $display("warm request test done");
        // Unmapped place answers with an error
        rd(8'h40, rdata); chk({30'h0, resp}, {30'h0, 2'h2});
        chk(rdata, 32'h0);
        wr(8'h40, 32'h1, resp); chk({30'h0, resp}, {30'h0, 2'h2});
        $display("unmapped access test done");
        results();
    end
endmodule
